//--- src/calendar_clock_module_pkg.sv
// Purpose: shared constants, types and BCD helpers of the calendar clock
// Assumes: 16-bit register data in the low half of a 32-bit bus word
// Notes: all time fields are packed BCD
package calendar_clock_module_pkg;
  // ==========================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] OFS_CFG = 8'h00;
  localparam logic [7:0] OFS_TVAL = 8'h04;
  localparam logic [7:0] OFS_AVAL = 8'h08;
  localparam logic [7:0] OFS_ACFG = 8'h0c;
  localparam logic [7:0] OFS_KEY = 8'h10;
  // ==========================================================
  // Field positions of the configuration register
  localparam int B_EN = 15;
  localparam int B_WREN = 13;
  localparam int B_OE = 10;
  localparam int B_PTR = 8;
  // ==========================================================
  // Window pointer codes
  localparam logic [1:0] PTR_MS = 2'h0;
  localparam logic [1:0] PTR_WH = 2'h1;
  localparam logic [1:0] PTR_MD = 2'h2;
  localparam logic [1:0] PTR_YR = 2'h3;
  // ==========================================================
  // Unlock key bytes and reset values
  localparam logic [7:0] KEY1 = 8'h55;
  localparam logic [7:0] KEY2 = 8'haa;
  localparam logic [15:0] ACFG_RST = 16'h0000;
  localparam logic [7:0] CAL_RST = 8'h00;
  // ==========================================================
  // Crystal timing
  localparam int unsigned XTAL_HZ = 32768;
  localparam logic [15:0] PRESC_TERM = 16'(XTAL_HZ - 1);
  localparam logic [15:0] HALF_CNT = 16'(XTAL_HZ / 2);
  localparam logic [15:0] SYNC_WIN = 16'h0020;
  // ==========================================================
  // BCD limits
  localparam logic [7:0] BCD_01 = 8'h01;
  localparam logic [7:0] BCD_59 = 8'h59;
  localparam logic [7:0] BCD_23 = 8'h23;
  localparam logic [7:0] BCD_12 = 8'h12;
  localparam logic [7:0] BCD_99 = 8'h99;
  localparam logic [7:0] WDAY_MAX = 8'h06;
  // ==========================================================
  // Types
  typedef struct packed {
    logic [7:0] year;
    logic [7:0] month;
    logic [7:0] day;
    logic [7:0] wday;
    logic [7:0] hour;
    logic [7:0] min;
    logic [7:0] sec;
  } calendar_clock_module_time_t;
  typedef enum logic [2:0] {
    KEY_IDLE = 3'b001,
    KEY_GOT55 = 3'b010,
    KEY_ARMED = 3'b100
  } calendar_clock_module_key_t;
  localparam calendar_clock_module_time_t TIME_RST = '{8'h00, BCD_01, BCD_01, 8'h00,
                                      8'h00, 8'h00, 8'h00};
  // ==========================================================
  // BCD increment, no wrap
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
  endfunction
  // Last day of a month; year mod 4 from BCD since 10 = 2 mod 4
  function automatic logic [7:0] days_in(input logic [7:0] m,
                                         input logic [7:0] y);
    logic [1:0] r;
    r = {y[4], 1'b0} + y[1:0];
    case (m)
      8'h02: days_in = (r == 2'h0) ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: days_in = 8'h30;
      default: days_in = 8'h31;
    endcase
  endfunction
endpackage

//--- src/calendar_clock_module_regs.sv
// Purpose: calendar clock counters and their register windows
// Assumes: classic Wishbone slave, one wait state on every access
// Notes: RST acts as the power-on reset; crystal pin is asynchronous
//
// Chosen here: register access over Wishbone and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - time pointer picks min/sec, wday/hour, month/day or year.
// - high-byte time write steps pointer down while write enable is set, stopping at zero.
// - alarm pointer picks alarm min/sec, wday/hour, month/day or none.
// - high-byte alarm write steps alarm pointer down, stopping at zero.
// - any window read steps its pointer; only high writes step it.
// - time registers take writes only while write enable is set.
// - write enable sets only right after key bytes 55h then AAh.
// - module enable bit changes only while write enable is set.
// - read-sync bit flags a rollover ripple about to happen.
// - half-second bit shows second half; low min/sec write clears it.
// - output enable bit gates the seconds clock pin.
// - signed calibration adjusts pulses per minute in steps of four.
// - configuration register is initialised only by power-on reset.
// - time and alarm fields are kept in BCD.
// - counters advance from the 32.768 kHz crystal input.
module calendar_clock_module_regs
  import calendar_clock_module_pkg::*;
(
  input wire logic SYS_CLK, // System clock
  input wire logic RST, // Power-on reset
  input wire logic WB_CYC_I, // Bus cycle
  input wire logic WB_STB_I, // Strobe
  input wire logic WB_WE_I, // Write
  input wire logic [7:0] WB_ADR_I, // Byte address
  input wire logic [3:0] WB_SEL_I, // Byte lanes
  input wire logic [31:0] WB_DAT_I, // Write data
  output logic [31:0] WB_DAT_O, // Read data
  output logic WB_ACK_O, // Acknowledge
  input wire logic XTAL_IN, // Crystal clock pin
  output logic CLK_OUT // Seconds clock pin
);
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (RST);

  // ==========================================================
  // State
  logic [2:0] xs, next_xs;
  logic xlvl, next_xlvl;
  logic [15:0] presc, next_presc;
  calendar_clock_module_time_t tm, next_tm, alm, next_alm;
  logic en, next_en, wren, next_wren, oe, next_oe;
  logic [1:0] tptr, next_tptr;
  logic [7:0] cal, next_cal;
  logic [15:0] acfg, next_acfg;
  calendar_clock_module_key_t key, next_key;
  logic ack, next_ack, pin, next_pin;
  logic [31:0] dat, next_dat;
  logic [15:0] rdv, adj, term, d;
  logic [7:0] dmax;
  logic xrise, tick, half, sync, acc, com, wr, rd;
  logic c_min, c_hr, c_day, c_mon, c_yr;
  logic hit_cfg, hit_tv, hit_av, hit_acfg, hit_key;
  logic [1:0] aptr;

  // ==========================================================
  // Crystal edge; a change counts once the two late stages agree
  always_comb
  begin
    next_xs = {xs[1:0], XTAL_IN};
    next_xlvl = (xs[1] == xs[2]) ? xs[2] : xlvl;
  end
  assign xrise = (xs[1] == xs[2]) & xs[2] & ~xlvl;

  // ==========================================================
  // Second timing and calibration
  // First second of each minute is stretched or shortened
  always_comb
  begin
    adj = (tm.sec == 8'h00) ? {{6{cal[7]}}, cal, 2'b00} : 16'h0000;
    term = PRESC_TERM - adj;
  end
  assign tick = en & xrise & (presc == term);
  assign half = (presc >= HALF_CNT);
  // Flag a window ahead of the tick so twice-read data is safe
  assign sync = en & (presc + SYNC_WIN >= term);
  assign dmax = days_in(tm.month, tm.year);
  assign aptr = acfg[B_PTR +: 2];
  // Carry chain; a field rolls only when all lower ones are at the top
  assign c_min = tick & (tm.sec == BCD_59);
  assign c_hr = c_min & (tm.min == BCD_59);
  assign c_day = c_hr & (tm.hour == BCD_23);
  assign c_mon = c_day & (tm.day == dmax);
  assign c_yr = c_mon & (tm.month == BCD_12);

  // ==========================================================
  // Bus decode; an access takes effect at the edge that sees ack
  assign acc = WB_CYC_I & WB_STB_I;
  assign com = acc & ack;
  assign wr = com & WB_WE_I;
  assign rd = com & ~WB_WE_I;
  assign d = WB_DAT_I[15:0];
  assign hit_cfg = ({WB_ADR_I[7:2], 2'b00} == OFS_CFG);
  assign hit_tv = ({WB_ADR_I[7:2], 2'b00} == OFS_TVAL);
  assign hit_av = ({WB_ADR_I[7:2], 2'b00} == OFS_AVAL);
  assign hit_acfg = ({WB_ADR_I[7:2], 2'b00} == OFS_ACFG);
  assign hit_key = ({WB_ADR_I[7:2], 2'b00} == OFS_KEY);
  // Byte-lane merge; lanes left unselected keep their old byte
  function automatic logic [15:0] lane_mix(input logic [15:0] old,
                                           input logic [15:0] nw,
                                           input logic [1:0] sel);
    lane_mix = {sel[1] ? nw[15:8] : old[15:8], sel[0] ? nw[7:0] : old[7:0]};
  endfunction

  // ==========================================================
  // Read mux; unmapped words and the key read as zero
  always_comb
  begin
    rdv = 16'h0000;
    if (hit_cfg)
      rdv = {en, 1'b0, wren, sync, half, oe, tptr, cal};
    else if (hit_tv)
      case (tptr)
        PTR_MS: rdv = {tm.min, tm.sec};
        PTR_WH: rdv = {tm.wday, tm.hour};
        PTR_MD: rdv = {tm.month, tm.day};
        default: rdv = {8'h00, tm.year};
      endcase
    else if (hit_av)
      case (aptr)
        PTR_MS: rdv = {alm.min, alm.sec};
        PTR_WH: rdv = {alm.wday, alm.hour};
        PTR_MD: rdv = {alm.month, alm.day};
        default: rdv = 16'h0000;
      endcase
    else if (hit_acfg)
      rdv = acfg;
  end

  // ==========================================================
  // Next state of counters, registers and bus answer
  always_comb
  begin
    next_tm = tm;
    next_alm = alm;
    next_presc = presc;
    next_en = en;
    next_wren = wren;
    next_oe = oe;
    next_tptr = tptr;
    next_cal = cal;
    next_acfg = acfg;
    next_key = key;
    next_ack = acc & ~ack;
    next_dat = dat;
    next_pin = oe & en & half;
    // Data is captured the cycle before ack so it stands with it
    if (acc & ~ack)
      next_dat = {16'h0000, rdv};
    if (en & xrise)
      next_presc = tick ? 16'h0000 : presc + 16'h0001;
    // BCD cascade, one step per second
    if (tick)
      next_tm.sec = (tm.sec == BCD_59) ? 8'h00 : bcd_inc(tm.sec);
    if (c_min)
      next_tm.min = (tm.min == BCD_59) ? 8'h00 : bcd_inc(tm.min);
    if (c_hr)
      next_tm.hour = (tm.hour == BCD_23) ? 8'h00 : bcd_inc(tm.hour);
    if (c_day)
    begin
      next_tm.wday = (tm.wday == WDAY_MAX) ? 8'h00 : tm.wday + 8'h01;
      next_tm.day = (tm.day == dmax) ? BCD_01 : bcd_inc(tm.day);
    end
    if (c_mon)
      next_tm.month = (tm.month == BCD_12) ? BCD_01 : bcd_inc(tm.month);
    if (c_yr)
      next_tm.year = (tm.year == BCD_99) ? 8'h00 : bcd_inc(tm.year);
    // Any other committed access breaks the key sequence
    if (com)
      next_key = KEY_IDLE;
    // Reads step the window pointer whatever the byte lanes
    if (rd & hit_tv & (tptr != PTR_MS))
      next_tptr = tptr - 2'h1;
    if (rd & hit_av & (aptr != PTR_MS))
      next_acfg[B_PTR +: 2] = aptr - 2'h1;
    if (wr & hit_cfg)
    begin
      if (WB_SEL_I[1])
      begin
        if (wren)
          next_en = d[B_EN];
        if (~d[B_WREN])
          next_wren = 1'b0;
        else if (key == KEY_ARMED)
          next_wren = 1'b1;
        next_oe = d[B_OE];
        next_tptr = d[B_PTR +: 2];
      end
      if (WB_SEL_I[0])
        next_cal = d[7:0];
    end
    // Locked writes leave both fields and pointer alone
    if (wr & hit_tv & wren)
    begin
      case (tptr)
        PTR_MS: {next_tm.min, next_tm.sec} =
          lane_mix({next_tm.min, next_tm.sec}, d, WB_SEL_I[1:0]);
        PTR_WH: {next_tm.wday, next_tm.hour} =
          lane_mix({next_tm.wday, next_tm.hour}, d, WB_SEL_I[1:0]);
        PTR_MD: {next_tm.month, next_tm.day} =
          lane_mix({next_tm.month, next_tm.day}, d, WB_SEL_I[1:0]);
        default: next_tm.year = WB_SEL_I[0] ? d[7:0] : next_tm.year;
      endcase
      if ((tptr == PTR_MS) & WB_SEL_I[0])
        next_presc = 16'h0000;
      if (WB_SEL_I[1] & (tptr != PTR_MS))
        next_tptr = tptr - 2'h1;
    end
    if (wr & hit_av)
    begin
      case (aptr)
        PTR_MS: {next_alm.min, next_alm.sec} =
          lane_mix({alm.min, alm.sec}, d, WB_SEL_I[1:0]);
        PTR_WH: {next_alm.wday, next_alm.hour} =
          lane_mix({alm.wday, alm.hour}, d, WB_SEL_I[1:0]);
        PTR_MD: {next_alm.month, next_alm.day} =
          lane_mix({alm.month, alm.day}, d, WB_SEL_I[1:0]);
        default: next_alm = alm;
      endcase
      if (WB_SEL_I[1] & (aptr != PTR_MS))
        next_acfg[B_PTR +: 2] = aptr - 2'h1;
    end
    if (wr & hit_acfg)
      next_acfg = lane_mix(acfg, d, WB_SEL_I[1:0]);
    if (wr & hit_key & WB_SEL_I[0])
    begin
      case (key)
        KEY_GOT55: next_key = (d[7:0] == KEY2) ? KEY_ARMED : KEY_IDLE;
        default: next_key = KEY_IDLE;
      endcase
      if (d[7:0] == KEY1)
        next_key = KEY_GOT55;
    end
  end

  // ==========================================================
  // Registers; only the power-on reset initialises them
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      xs <= 3'h0;
      xlvl <= 1'b0;
      presc <= 16'h0000;
      tm <= TIME_RST;
      alm <= TIME_RST;
      en <= 1'b0;
      wren <= 1'b0;
      oe <= 1'b0;
      tptr <= PTR_MS;
      cal <= CAL_RST;
      acfg <= ACFG_RST;
      key <= KEY_IDLE;
      ack <= 1'b0;
      dat <= 32'h0000_0000;
      pin <= 1'b0;
    end
    else
    begin
      xs <= next_xs;
      xlvl <= next_xlvl;
      presc <= next_presc;
      tm <= next_tm;
      alm <= next_alm;
      en <= next_en;
      wren <= next_wren;
      oe <= next_oe;
      tptr <= next_tptr;
      cal <= next_cal;
      acfg <= next_acfg;
      key <= next_key;
      ack <= next_ack;
      dat <= next_dat;
      pin <= next_pin;
    end
  end
  assign WB_ACK_O = ack;
  assign WB_DAT_O = dat;
  assign CLK_OUT = pin;

  // ==========================================================
  // Checks
  route_time_a: assert property (
    rd & hit_tv & (tptr == PTR_MS) |->
    WB_DAT_O[15:0] == {$past(tm.min), $past(tm.sec)})
    else $error("time window misrouted");
  tptr_step_a: assert property (
    wr & hit_tv & wren & WB_SEL_I[1] & (tptr != PTR_MS) |=>
    tptr == $past(tptr) - 2'h1)
    else $error("time pointer did not step");
  tptr_floor_a: assert property (
    wr & hit_tv & (tptr == PTR_MS) |=> tptr == PTR_MS)
    else $error("time pointer left zero");
  route_alarm_a: assert property (
    rd & hit_av & (aptr == PTR_YR) |-> WB_DAT_O[15:0] == 16'h0000)
    else $error("empty alarm slot read nonzero");
  aptr_step_a: assert property (
    wr & hit_av & WB_SEL_I[1] & (aptr != PTR_MS) |=>
    aptr == $past(aptr) - 2'h1)
    else $error("alarm pointer did not step");
  read_step_a: assert property (
    rd & hit_tv & (tptr == PTR_MD) |=> tptr == PTR_WH && !ack)
    else $error("read did not step pointer");
  lock_out_a: assert property (
    wr & hit_tv & ~wren & ~tick |=> tm == $past(tm) && $stable(tptr))
    else $error("locked write took effect");
  key_gate_a: assert property (
    $rose(wren) |-> $past(key) == KEY_ARMED)
    else $error("write enable set without key");
  en_gate_a: assert property (
    $changed(en) |-> $past(wren))
    else $error("enable changed while locked");
  half_clr_a: assert property (
    wr & hit_tv & wren & (tptr == PTR_MS) & WB_SEL_I[0] |=> ~half)
    else $error("half-second not cleared");
  out_gate_a: assert property (
    ~oe [*2] |-> ~CLK_OUT)
    else $error("output pin active while disabled");
  cal_len_a: assert property (
    tick |-> presc == PRESC_TERM -
    ((tm.sec == 8'h00) ? {{6{cal[7]}}, cal, 2'b00} : 16'h0000))
    else $error("calibrated period wrong");
  minute_c: cover property (tick & (tm.sec == BCD_59));
  unlock_c: cover property ($rose(wren));
  walk_c: cover property (rd & hit_tv & (tptr == PTR_WH));
endmodule
`default_nettype wire

//--- verif/tb_top.sv
// Purpose: self-checking bench for the calendar clock register windows
// Assumes: one wait state per Wishbone access; crystal pin held idle
// Notes: half-second counts need 16384 crystal rises, too long to run
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import calendar_clock_module_pkg::*;
  typedef struct packed {
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [15:0] dat;
  } calendar_clock_module_row_t;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [3:0] wb_sel = 4'h0;
  logic [31:0] wb_wdat = 32'h00000000;
  logic [31:0] wb_rdat;
  logic wb_ack;
  logic xtal = 1'b0;
  logic clk_out;
  logic [31:0] rd;
  calendar_clock_module_row_t rows[$];
  int fails = 0;
  int comparisons = 0;
  int cycles = 0;
  // ==========================================================
  // Clock, 5 ns period
  initial
  begin
    forever #2.5 sys_clk = ~sys_clk;
  end
  calendar_clock_module_regs u_dut (
    .SYS_CLK(sys_clk),
    .RST(rst),
    .WB_CYC_I(wb_cyc),
    .WB_STB_I(wb_stb),
    .WB_WE_I(wb_we),
    .WB_ADR_I(wb_adr),
    .WB_SEL_I(wb_sel),
    .WB_DAT_I(wb_wdat),
    .WB_DAT_O(wb_rdat),
    .WB_ACK_O(wb_ack),
    .XTAL_IN(xtal),
    .CLK_OUT(clk_out)
  );
  // ==========================================================
  // Verdict; one place ends the run
  task automatic final_report();
    $display("checks %0d mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Watchdog well above the expected few hundred cycles
  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    if (cycles >= 20000)
    begin
      fails = fails + 1;
      $display("[FAIL] watchdog expected finish seen hang");
      final_report();
    end
  end
  task automatic check(input string nm, input logic [31:0] exp,
                       input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // ==========================================================
  // Classic single cycle; held until ack is sampled high
  task automatic wb_cycle(input logic we, input logic [7:0] adr,
                          input logic [3:0] sel, input logic [15:0] wd,
                          output logic [31:0] rdat);
    int n;
    n = 0;
    @(posedge sys_clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_sel <= sel;
    wb_wdat <= {16'h0000, wd};
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (wb_ack !== 1'b1 && n < 50);
    if (n >= 50)
      check("ack wait", 32'h1, 32'h0);
    rdat = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    // Keeps the bus idle for a cycle between accesses
    @(posedge sys_clk);
  endtask
  task automatic add(input logic we, input logic [7:0] adr,
                     input logic [3:0] sel, input logic [15:0] dat);
    rows.push_back('{we, adr, sel, dat});
  endtask
  // ==========================================================
  // Main sequence
  initial
  begin
    // Reads carry the expected value, writes the data sent
    add(1'b0, OFS_CFG, 4'h3, 16'h0000);
    add(1'b0, OFS_KEY, 4'h3, 16'h0000);
    add(1'b0, 8'h14, 4'h3, 16'h0000);
    add(1'b1, OFS_CFG, 4'h3, 16'h0100);
    add(1'b1, OFS_TVAL, 4'h3, 16'h0512);
    add(1'b0, OFS_CFG, 4'h3, 16'h0100);
    add(1'b0, OFS_TVAL, 4'h3, 16'h0000);
    add(1'b0, OFS_CFG, 4'h3, 16'h0000);
    add(1'b1, OFS_KEY, 4'h1, 16'h0055);
    add(1'b1, OFS_KEY, 4'h1, 16'h00aa);
    add(1'b1, OFS_CFG, 4'h2, 16'ha000);
    add(1'b0, OFS_CFG, 4'h3, 16'h2000);
    add(1'b1, OFS_CFG, 4'h3, 16'h2300);
    add(1'b1, OFS_TVAL, 4'h3, 16'h0024);
    add(1'b1, OFS_TVAL, 4'h3, 16'h1231);
    add(1'b1, OFS_TVAL, 4'h3, 16'h0323);
    add(1'b1, OFS_TVAL, 4'h3, 16'h5958);
    add(1'b1, OFS_TVAL, 4'h3, 16'h4507);
    add(1'b0, OFS_CFG, 4'h3, 16'h2000);
    add(1'b1, OFS_CFG, 4'h3, 16'h2300);
    add(1'b0, OFS_TVAL, 4'h3, 16'h0024);
    add(1'b0, OFS_TVAL, 4'h3, 16'h1231);
    add(1'b0, OFS_TVAL, 4'h3, 16'h0323);
    add(1'b0, OFS_TVAL, 4'h3, 16'h4507);
    add(1'b0, OFS_TVAL, 4'h3, 16'h4507);
    add(1'b1, OFS_CFG, 4'h3, 16'h2100);
    add(1'b1, OFS_TVAL, 4'h1, 16'h0005);
    add(1'b0, OFS_CFG, 4'h3, 16'h2100);
    add(1'b0, OFS_TVAL, 4'h3, 16'h0305);
    add(1'b1, OFS_ACFG, 4'h3, 16'h0200);
    add(1'b1, OFS_AVAL, 4'h3, 16'h1225);
    add(1'b1, OFS_AVAL, 4'h3, 16'h0410);
    add(1'b1, OFS_AVAL, 4'h3, 16'h3015);
    add(1'b0, OFS_ACFG, 4'h3, 16'h0000);
    add(1'b1, OFS_ACFG, 4'h3, 16'h0300);
    add(1'b1, OFS_AVAL, 4'h3, 16'hffff);
    add(1'b0, OFS_ACFG, 4'h3, 16'h0200);
    add(1'b0, OFS_AVAL, 4'h3, 16'h1225);
    add(1'b0, OFS_AVAL, 4'h3, 16'h0410);
    add(1'b0, OFS_AVAL, 4'h3, 16'h3015);
    add(1'b0, OFS_AVAL, 4'h3, 16'h3015);
    add(1'b1, OFS_ACFG, 4'h3, 16'h0300);
    add(1'b0, OFS_AVAL, 4'h3, 16'h0000);
    add(1'b0, OFS_ACFG, 4'h3, 16'h0200);
    add(1'b1, OFS_CFG, 4'h3, 16'h7c80);
    add(1'b0, OFS_CFG, 4'h3, 16'h2480);
    add(1'b1, OFS_CFG, 4'h3, 16'ha480);
    add(1'b0, OFS_CFG, 4'h3, 16'ha480);
    add(1'b1, OFS_CFG, 4'h3, 16'h8480);
    add(1'b1, OFS_CFG, 4'h3, 16'h0480);
    add(1'b0, OFS_CFG, 4'h3, 16'h8480);
    add(1'b1, OFS_TVAL, 4'h3, 16'h1111);
    add(1'b0, OFS_TVAL, 4'h3, 16'h4507);
    add(1'b1, OFS_KEY, 4'h1, 16'h0055);
    add(1'b1, OFS_KEY, 4'h1, 16'h00aa);
    add(1'b0, OFS_CFG, 4'h3, 16'h8480);
    add(1'b1, OFS_CFG, 4'h3, 16'ha480);
    add(1'b0, OFS_CFG, 4'h3, 16'h8480);
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    // Table walk
    foreach (rows[i])
    begin
      wb_cycle(rows[i].we, rows[i].adr, rows[i].sel, rows[i].dat, rd);
      if (!rows[i].we)
        check($sformatf("row %0d", i), {16'h0000, rows[i].dat}, rd);
    end
    $display("test table done");
    // Mid-run reset restores ack, seconds pin, config, min/sec and alarm config
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    check("ack in reset", 32'h0, {31'h0, wb_ack});
    rst <= 1'b0;
    @(posedge sys_clk);
    check("seconds pin", 32'h0, {31'h0, clk_out});
    wb_cycle(1'b0, OFS_CFG, 4'h3, 16'h0000, rd);
    check("config", 32'h0, rd);
    wb_cycle(1'b0, OFS_TVAL, 4'h3, 16'h0000, rd);
    check("min sec", 32'h0, rd);
    wb_cycle(1'b0, OFS_ACFG, 4'h3, 16'h0000, rd);
    check("alarm config", {16'h0000, ACFG_RST}, rd);
    $display("test reset done");
    final_report();
  end
endmodule
`default_nettype wire
